// >>> verilog/hppm_consts.vh
/*
 * Constants for the host port pad multiplexer: host mode codes, reset
 * levels and pad counts.
 * Assumes it is included by bare name from the design file.
 */
`ifndef HPPM_CONSTS_VH
`define HPPM_CONSTS_VH

// Host interface mode codes, one-hot
`define HPPM_MODE_W 3
`define HPPM_MODE_NONE 3'h0
`define HPPM_MODE_UART 3'h1
`define HPPM_MODE_SDIO 3'h2
`define HPPM_MODE_SPI 3'h4

// Width of the shared SDIO/SPI pad group: clock, command, data 0..3
`define HPPM_SD_PADS 6
`define HPPM_SD_CLK 0
`define HPPM_SD_CMD 1
`define HPPM_SD_D0 2
`define HPPM_SD_D1 3
`define HPPM_SD_D2 4
`define HPPM_SD_D3 5

// Antenna select pad count
`define HPPM_ANT_PADS 3

// Reset and idle levels
`define HPPM_SLEEP_IND_RST 1'h1
`define HPPM_OE_OFF 1'h0

`endif

// >>> verilog/hppm_pin_mux.v
/*
 * Host port pad multiplexer with reset and supply-valid handling.
 * Routes UART, SDIO or SPI-slave host functions onto shared pads, places
 * the optional wake, flow-control and coexistence functions, and keeps
 * every pad but the reset pad released at power-up, during reset and in sleep.
 * Assumes all inputs are synchronous to core_clk; pads are split into
 * input, output and output enable, resolved outside this module.
 */
`timescale 1ns/1ns
`include "hppm_consts.vh"

module hppm_pin_mux #(
    parameter ANT_W = `HPPM_ANT_PADS
) (
    input wire core_clk,
    input wire reset,
    // Power and reset
    input wire power_on_control_input,
    input wire batterySupplyValid,
    input wire coreRegulatorValid,
    output reg supply_valid_output,
    input wire resetPadIn,
    output wire resetPadOut,
    output wire resetPadOe,
    output wire digitalReset,
    output wire analogReset,
    // Boot and mode selection
    input wire bootDone,
    input wire [`HPPM_MODE_W-1:0] hostModeSelect,
    input wire uartFlowEnable,
    input wire externalRfSwitch,
    input wire sleepRequest,
    // UART core side
    input wire uartTxData,
    output reg uartRxData,
    input wire uartRtsCore,
    output reg uartCtsCore,
    input wire packetPending,
    output wire packetSendAllowed,
    // UART pads
    input wire host_uart_serial_in,
    output reg host_uart_serial_out,
    output reg uartTxOe,
    output reg host_uart_request_to_send,
    output reg rtsOe,
    input wire host_uart_clear_to_send,
    input wire host_ready_for_packet,
    // SDIO/SPI shared pads
    input wire [`HPPM_SD_PADS-1:0] sdPadIn,
    output reg [`HPPM_SD_PADS-1:0] sdPadOut,
    output reg [`HPPM_SD_PADS-1:0] sdPadOe,
    // SDIO core side
    input wire [`HPPM_SD_PADS-1:0] sdCoreOut,
    input wire [`HPPM_SD_PADS-1:0] sdCoreOe,
    output reg [`HPPM_SD_PADS-1:0] sdCoreIn,
    // SPI slave core side
    output reg slave_serial_clock_pad,
    output reg slave_serial_select_low,
    output reg slave_serial_data_in,
    input wire slave_serial_data_out,
    input wire slave_serial_host_interrupt,
    // Wake, coexistence and antenna
    input wire wakeHostRequest,
    output reg wakeHostPad,
    output reg wakeHostOe,
    input wire coexGrantCore,
    output reg coex_grant_out,
    output reg coexGrantOe,
    input wire coex_request_in,
    input wire coex_priority_in,
    output reg coexRequest,
    output reg coexPriority,
    input wire [ANT_W-1:0] antennaSelect,
    output reg [ANT_W-1:0] antennaPad,
    output reg [ANT_W-1:0] antennaOe,
    // Sleep and boot bypass
    output reg device_sleep_indication,
    input wire boot_bypass_or_wake_in,
    output reg bootBypass,
    output reg wakeRequest
);

    // Mode latch state machine, one-hot.
    // BOOT waits for the boot loader to finish and is the only state in
    // which the host mode select is looked at. RUN is normal operation
    // with every selected pad function live. SLEEP releases all pads and
    // waits for the bypass/wake input to go high.
    // Any reset, from the bench-side reset or the reset pad, returns the
    // machine to BOOT, so a new mode can only be chosen after a reset.
    localparam ST_BOOT = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_SLEEP = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [`HPPM_MODE_W-1:0] hostMode;
    wire anyReset;
    wire active;
    wire isUart;
    wire isSdio;
    wire isSpi;

    // Accept only a single one-hot mode code; anything else means no host
    function [`HPPM_MODE_W-1:0] cleanMode;
        input [`HPPM_MODE_W-1:0] m;
        begin
            case (m)
                `HPPM_MODE_UART: cleanMode = `HPPM_MODE_UART;
                `HPPM_MODE_SDIO: cleanMode = `HPPM_MODE_SDIO;
                `HPPM_MODE_SPI: cleanMode = `HPPM_MODE_SPI;
                default: cleanMode = `HPPM_MODE_NONE;
            endcase
        end
    endfunction

    // Reset fan-out.
    // The reset pad is open-drain from our side: we only ever pull it
    // low, so an external supervisor may hold it low as well without a
    // drive fight. The pad level seen back through resetPadIn is the
    // wired result of both parties, which is why the digital reset is
    // taken from the pad and not from the power-on input alone.
    // Limitation: these reset nets are combinational, so a glitch on the
    // pad reaches digitalReset directly; the pad cell is expected to
    // filter spikes before they get here.
    // pad pulled low: only driven, never released high by us
    assign resetPadOut = 1'h0;
    assign resetPadOe = ~power_on_control_input;
    assign analogReset = ~power_on_control_input;
    // reset pad clears digital only; resolved pad level seen here
    assign digitalReset = ~power_on_control_input | ~resetPadIn;
    // relies on the power-on input staying low until supplies settle
    assign anyReset = reset | digitalReset;

    // Supply-valid is registered so a short dip of either supply flag
    // shows up one clock later as a clean low, never as a glitch on the
    // output. It is cleared by the bench-side reset and the full reset, not the pad reset,
    // because the supplies do not depend on digital state.
    // supply-valid follows both always-on supplies, low at start
    always @(posedge core_clk) begin
        if (reset | analogReset)
            supply_valid_output <= 1'h0;
        else
            supply_valid_output <= batterySupplyValid & coreRegulatorValid;
    end

    // Next state of the mode latch and sleep tracking.
    // Sleep may only be entered from RUN: a sleep request during boot is
    // ignored so the mode latch can never be skipped.
    // The wake input is the same pin as the boot bypass; in BOOT it is
    // only reported as a bypass and never moves the state machine.
    always @* begin
        next_state = state;
        case (state)
            ST_BOOT: if (bootDone) next_state = ST_RUN;
            ST_RUN: if (sleepRequest) next_state = ST_SLEEP;
            ST_SLEEP: if (boot_bypass_or_wake_in) next_state = ST_RUN;
            default: next_state = ST_BOOT;
        endcase
    end

    // The mode is captured on the single edge on which BOOT sees
    // bootDone. Later changes of hostModeSelect are ignored on purpose:
    // re-mapping live pads could make two functions drive one pad.
    // An illegal code is latched as "no host" and leaves all host pads
    // released rather than guessing at a mode.
    // mode captured once at boot end, held until next reset
    always @(posedge core_clk) begin
        if (anyReset) begin
            state <= ST_BOOT;
            hostMode <= `HPPM_MODE_NONE;
        end else begin
            state <= next_state;
            if (state == ST_BOOT && bootDone)
                hostMode <= cleanMode(hostModeSelect);
        end
    end

    // Mode decodes used by the pad mux; all of them are false outside
    // RUN, which is what releases every host pad in boot and in sleep.
    assign active = (state == ST_RUN);
    assign isUart = active && hostMode == `HPPM_MODE_UART;
    assign isSdio = active && hostMode == `HPPM_MODE_SDIO;
    assign isSpi = active && hostMode == `HPPM_MODE_SPI;
    // packet transfer gated by host readiness in UART mode only
    assign packetSendAllowed = isUart & host_ready_for_packet & packetPending;

    // Registered pad drive; everything released in boot, reset and sleep.
    // All pad outputs and enables but the reset pad's come from flip-flops so the pads never
    // see decode glitches while the mode or state changes.
    // Trade-off: every pad function lags its core signal by one clock,
    // and enables reach the pads one clock after the state changes.
    // Core-side inputs fed from pads are forced to their idle level when
    // the owning mode is not selected, so an unused core never sees
    // activity from a pad that belongs to another function.
    // Outputs whose enable is off still follow their core value; the
    // enable alone decides whether the pad is driven.
    always @(posedge core_clk) begin
        if (anyReset) begin
            host_uart_serial_out <= 1'h0;
            uartTxOe <= `HPPM_OE_OFF;
            host_uart_request_to_send <= 1'h0;
            rtsOe <= `HPPM_OE_OFF;
            sdPadOut <= {`HPPM_SD_PADS{1'h0}};
            sdPadOe <= {`HPPM_SD_PADS{`HPPM_OE_OFF}};
            wakeHostPad <= 1'h0;
            wakeHostOe <= `HPPM_OE_OFF;
            coex_grant_out <= 1'h0;
            coexGrantOe <= `HPPM_OE_OFF;
            antennaPad <= {ANT_W{1'h0}};
            antennaOe <= {ANT_W{`HPPM_OE_OFF}};
            device_sleep_indication <= `HPPM_SLEEP_IND_RST;
            uartRxData <= 1'h1;
            uartCtsCore <= 1'h0;
            sdCoreIn <= {`HPPM_SD_PADS{1'h0}};
            slave_serial_clock_pad <= 1'h0;
            slave_serial_select_low <= 1'h1;
            slave_serial_data_in <= 1'h0;
            coexRequest <= 1'h0;
            coexPriority <= 1'h0;
            bootBypass <= 1'h0;
            wakeRequest <= 1'h0;
        end else begin

            // UART transmit pad, receive pad used as input only
            host_uart_serial_out <= uartTxData;
            uartTxOe <= isUart;
            uartRxData <= isUart ? host_uart_serial_in : 1'h1;

            // flow control pads only when enabled
            host_uart_request_to_send <= uartRtsCore;
            rtsOe <= isUart & uartFlowEnable;
            uartCtsCore <= isUart & uartFlowEnable & host_uart_clear_to_send;

            // SDIO lines follow the SDIO core's drive
            sdPadOut <= sdCoreOut;
            sdPadOe <= isSdio ? sdCoreOe : {`HPPM_SD_PADS{`HPPM_OE_OFF}};
            sdCoreIn <= isSdio ? sdPadIn : {`HPPM_SD_PADS{1'h0}};

            // SPI shares the SDIO pads: clock, command and data 0 become
            // inputs, data 1 and data 2 outputs, data 3 stays released.
            // The if below overrides the SDIO drive of the two output pads.
            // SPI slave inputs and data-out on the data 1 pad
            slave_serial_clock_pad <= isSpi & sdPadIn[`HPPM_SD_CLK];
            slave_serial_select_low <= ~isSpi | sdPadIn[`HPPM_SD_CMD];
            slave_serial_data_in <= isSpi & sdPadIn[`HPPM_SD_D0];
            if (isSpi) begin
                sdPadOut[`HPPM_SD_D1] <= slave_serial_data_out;
                sdPadOe[`HPPM_SD_D1] <= 1'h1;
                // host interrupt on the data 2 pad
                sdPadOut[`HPPM_SD_D2] <= slave_serial_host_interrupt;
                sdPadOe[`HPPM_SD_D2] <= 1'h1;
            end

            // Optional functions below except the antenna pads are driven whenever running; their
            // software selection is outside this block.
            // wakeup indication; weak pull-down keeps it low when off
            wakeHostPad <= wakeHostRequest;
            wakeHostOe <= active;
            coex_grant_out <= coexGrantCore;
            coexGrantOe <= active;
            // arbiter inputs sampled only while running
            coexRequest <= active & coex_request_in;
            coexPriority <= active & coex_priority_in;

            // antenna pads driven only with an external switch
            antennaPad <= antennaSelect;
            antennaOe <= {ANT_W{active & externalRfSwitch}};

            // Taken from next_state so the host hears about sleep on the
            // same edge the state machine enters it.
            // sleep indication low while asleep, high otherwise
            device_sleep_indication <= (next_state != ST_SLEEP);
            // bypass during boot, wake pulse in sleep
            bootBypass <= (state == ST_BOOT) & boot_bypass_or_wake_in;
            wakeRequest <= (state == ST_SLEEP) & boot_bypass_or_wake_in;
        end
    end

endmodule // hppm_pin_mux

// >>> testbench/hppm_pin_mux_assertions.sv
/* Port checker for hppm_pin_mux.
   Assumes it is bound by name onto that module. */
`timescale 1ns/1ns
`include "hppm_consts.vh"
module hppm_pin_mux_checker #(
    parameter ANT_W = 3
) (
    input wire core_clk, reset, power_on_control_input, resetPadIn,
    input wire resetPadOut, resetPadOe, digitalReset, analogReset,
    input wire batterySupplyValid, coreRegulatorValid, supply_valid_output,
    input wire uartTxOe, rtsOe, uartFlowEnable, coexGrantOe,
    input wire packetSendAllowed, packetPending, host_ready_for_packet,
    input wire device_sleep_indication, sleepRequest, boot_bypass_or_wake_in,
    input wire [`HPPM_SD_PADS-1:0] sdPadOe,
    input wire [ANT_W-1:0] antennaOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Pad enables except wakeHostOe and resetPadOe; all must be off while asleep or fresh from reset
    wire anyOe = uartTxOe | rtsOe | coexGrantOe | (|sdPadOe) | (|antennaOe);
    rst_pad_a: assert property (!power_on_control_input |->
        resetPadOe && !resetPadOut) else $error("reset pad not low");
    dig_reset_a: assert property (digitalReset ==
        (!power_on_control_input || !resetPadIn)) else $error("dig reset");
    full_reset_a: assert property (!power_on_control_input |->
        analogReset && digitalReset) else $error("full reset");
    supply_ok_a: assert property (supply_valid_output |->
        $past(batterySupplyValid && coreRegulatorValid)) else $error("supply");
    one_mode_a: assert property (uartTxOe |-> sdPadOe == 0)
        else $error("two host modes");
    flow_gate_a: assert property (rtsOe |-> $past(uartFlowEnable))
        else $error("rts without flow");
    packet_gate_a: assert property (packetSendAllowed |->
        host_ready_for_packet && packetPending) else $error("packet gate");
    sleep_quiet_a: assert property (!device_sleep_indication [*2] |->
        !anyOe) else $error("pad driven asleep");
    post_reset_a: assert property ($past(reset) |-> !anyOe)
        else $error("pad driven in reset");
    sleep_cause_a: assert property ($fell(device_sleep_indication) |->
        $past(sleepRequest) || $past(sleepRequest, 2)) else $error("sleep");
    wake_exit_a: assert property (!device_sleep_indication &&
        boot_bypass_or_wake_in |-> ##[1:2] device_sleep_indication)
        else $error("no wake");
    cover property (uartTxOe);
    cover property (|sdPadOe);
    cover property ($fell(device_sleep_indication));
endmodule // hppm_pin_mux_checker
bind hppm_pin_mux hppm_pin_mux_checker #(.ANT_W(ANT_W)) chk_u (.*);

// >>> testbench/hppm_host_model.sv
/* Host processor and coexistence arbiter model.
   Assumes a pad reads the device drive if enabled, else the host. */
`timescale 1ns/1ns
module hppm_host_model (
    input wire core_clk,
    input wire hostReady,
    input wire [5:0] sdPadOut,
    input wire [5:0] sdPadOe,
    output wire [5:0] sdPadIn,
    output wire host_ready_for_packet,
    output wire host_uart_serial_in,
    output wire host_uart_clear_to_send,
    output wire coex_request_in,
    output wire coex_priority_in
);
    reg [5:0] pat = 6'h0b;
    // Shift on the falling edge so the sampling edge sees settled data
    always @(negedge core_clk) begin
        pat <= {pat[4:0], ~pat[5]};
    end
    // Undriven lines never keep a stale level
    assign sdPadIn = (sdPadOe & sdPadOut) | (~sdPadOe & pat);
    assign host_ready_for_packet = hostReady;
    assign host_uart_serial_in = pat[0];
    assign host_uart_clear_to_send = pat[1];
    assign coex_request_in = pat[2];
    assign coex_priority_in = pat[3];
endmodule // hppm_host_model

// >>> testbench/hppm_pin_mux_tb.sv
/* Self-checking bench for hppm_pin_mux.
   Assumes design, checker and host model are compiled first. */
`timescale 1ns/1ns
`include "hppm_consts.vh"
module hppm_pin_mux_tb;
    logic core_clk = 0, reset = 1, power_on_control_input = 0, extRstN = 1;
    logic batterySupplyValid = 0, coreRegulatorValid = 0, bootDone = 0;
    logic uartFlowEnable = 0, externalRfSwitch = 0, sleepRequest = 0;
    logic uartTxData = 0, uartRtsCore = 0, packetPending = 0, hostReady = 0;
    logic wakeHostRequest = 0, coexGrantCore = 0, slave_serial_data_out = 0;
    logic slave_serial_host_interrupt = 0, boot_bypass_or_wake_in = 0;
    logic [2:0] hostModeSelect = 0, antennaSelect = 0, antennaPad, antennaOe;
    logic [5:0] sdCoreOut = 0, sdCoreOe = 0, sdPadIn, sdPadOut, sdPadOe;
    logic [5:0] sdCoreIn;
    logic supply_valid_output, resetPadOut, resetPadOe, digitalReset;
    logic analogReset, uartRxData, uartCtsCore, packetSendAllowed, rtsOe;
    logic host_uart_serial_in, host_uart_serial_out, uartTxOe, wakeHostOe;
    logic host_uart_request_to_send, host_uart_clear_to_send, wakeHostPad;
    logic host_ready_for_packet, slave_serial_clock_pad, slave_serial_data_in;
    logic slave_serial_select_low, coex_grant_out, coexGrantOe, coexRequest;
    logic coex_request_in, coex_priority_in, coexPriority, bootBypass;
    logic device_sleep_indication, wakeRequest;
    // Open-drain reset pad, pulled up outside
    wire resetPadIn = resetPadOe ? resetPadOut : extRstN;
    int bad_count = 0, cmp_count = 0;
    hppm_pin_mux dut_u (.*);
    hppm_host_model host_u (.*);
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task check(input logic [11:0] seen, exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task restart(input logic [2:0] m);
        reset = 1;
        step(1);
        reset = 0;
        bootDone = 1;
        hostModeSelect = m;
        step(1);
        bootDone = 0;
        step(2);
    endtask
    task power_seq;
        batterySupplyValid = 1;
        coreRegulatorValid = 1;
        power_on_control_input = 1;
        step(2);
        check(supply_valid_output, 1, "supply");
        coreRegulatorValid = 0;
        step(2);
        check(supply_valid_output, 0, "supply drop");
        coreRegulatorValid = 1;
        extRstN = 0;
        step(1);
        check({analogReset, digitalReset}, 1, "pad reset");
        extRstN = 1;
        step(1);
        check(digitalReset, 0, "reset off");
    endtask
    task none_run;
        reset = 1;
        step(1);
        reset = 0;
        boot_bypass_or_wake_in = 1;
        step(1);
        check(bootBypass, 1, "boot bypass");
        boot_bypass_or_wake_in = 0;
        restart(`HPPM_MODE_NONE);
        hostModeSelect = `HPPM_MODE_UART;
        bootDone = 1;
        step(3);
        bootDone = 0;
        check({uartTxOe, sdPadOe}, 0, "no host");
    endtask
    task uart_run;
        uartFlowEnable = 1;
        externalRfSwitch = 1;
        antennaSelect = 3'h5;
        coexGrantCore = 1;
        uartTxData = 1;
        uartRtsCore = 1;
        wakeHostRequest = 1;
        restart(`HPPM_MODE_UART);
        check({uartTxOe, rtsOe, host_uart_serial_out, sdPadOe}, 12'h1c0,
            "uart pads");
        check(uartRxData, host_uart_serial_in, "uart rx");
        check({antennaOe, antennaPad}, 12'h03d, "antenna");
        check({wakeHostOe, coexGrantOe, coex_grant_out}, 7, "wake");
        check(coexRequest, coex_request_in, "coex req");
        check(coexPriority, coex_priority_in, "coex prio");
        check({uartCtsCore, host_uart_request_to_send},
            {host_uart_clear_to_send, 1'h1}, "flow pads");
        check(wakeHostPad, 1, "wake pad");
        hostReady = 1;
        packetPending = 1;
        step(1);
        check(packetSendAllowed, 1, "send ok");
        hostReady = 0;
        step(1);
        check(packetSendAllowed, 0, "send held");
        uartFlowEnable = 0;
        step(2);
        check(rtsOe, 0, "rts off");
        sleepRequest = 1;
        step(2);
        sleepRequest = 0;
        step(1);
        check({device_sleep_indication, uartTxOe, antennaOe}, 0, "slp");
        boot_bypass_or_wake_in = 1;
        step(1);
        check(wakeRequest, 1, "wake pulse");
        boot_bypass_or_wake_in = 0;
        step(3);
        check({device_sleep_indication, uartTxOe}, 3, "awake");
    endtask
    task sdio_run;
        sdCoreOe = 6'h3c;
        sdCoreOut = 6'h28;
        restart(`HPPM_MODE_SDIO);
        check({sdPadOe, sdPadOut & sdPadOe}, 12'hf28, "sdio out");
        check(sdCoreIn, sdPadIn, "sdio in");
    endtask
    task spi_run;
        slave_serial_data_out = 1;
        slave_serial_host_interrupt = 1;
        restart(`HPPM_MODE_SPI);
        check({sdPadOe, sdPadOut & sdPadOe}, 12'h618, "spi out");
        check({slave_serial_clock_pad, slave_serial_select_low,
            slave_serial_data_in}, {sdPadIn[0], sdPadIn[1], sdPadIn[2]},
            "spi in");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence, power first so later resets start clean
    initial begin
        step(20);
        check({resetPadIn, resetPadOe, analogReset}, 3, "por");
        reset = 0;
        power_seq;
        none_run;
        uart_run;
        sdio_run;
        spi_run;
        print_verdict;
    end
    // Run needs about 60 cycles; 2000 leaves ample margin
    initial begin
        #80000;
        bad_count++;
        print_verdict;
    end
endmodule // hppm_pin_mux_tb
